/* File: cfg_diag_consts.svh */
// Offsets, field positions, reset values and widths for the pin data and diagnostic registers.
`ifndef CFG_DIAG_CONSTS_SVH
`define CFG_DIAG_CONSTS_SVH
`define PIN_DATA_OFFSET 8'hB6
`define DIAG0_OFFSET 8'hC0
`define PIN_DIR_OFFSET 8'hB4
`define PIN_COUNT 5
`define PIN_DATA_MASK 16'h001F
`define DIAG0_RESET 32'h00000001
`define DIAG0_BUS_HI 31
`define DIAG0_BUS_LO 24
`define DIAG0_DEV_HI 23
`define DIAG0_DEV_LO 19
`define DIAG0_ALT_ERR_BIT 18
`define DIAG0_CFG_MEM_BIT 2
`define DIAG0_CLKREQ_BIT 0
`define DIAG0_RW_MASK 32'h0004CF87
`define DIAG0_LANES 4
`define LANE_BITS 8
`define DIAG0_RSVD_HI_HI 15
`define DIAG0_RSVD_HI_LO 14
`define DIAG0_RSVD_MID_HI 11
`define DIAG0_RSVD_MID_LO 7
`define DIAG0_RSVD_LO_BIT 1
`define ALT_ERR_RESET 1'b0
`define CFG_MEM_RESET 1'b0
`define CLKREQ_RESET 1'b1
`define RSVD_HI_RESET 2'h0
`define RSVD_MID_RESET 5'h00
`define RSVD_LO_RESET 1'b0
`define ZERO16 16'h0000
`define ZERO32 32'h00000000
`endif

/* File: cfg_diag_pkg.sv */
// Types shared by the pin data and diagnostic register logic.
package cfg_diag_pkg;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [31:0] wdata;
		logic [3:0] be;
	} cfg_req_s;
	typedef struct packed {
		logic [7:0] bus_number;
		logic [4:0] device_number;
	} captured_id_s;
	typedef enum logic [1:0] {
		RESET_HOLD,
		RUNNING
	} reset_state_e;
endpackage

/* File: pin_cell.sv */
// One general-purpose pin: direction, output latch and read-back selection.
`timescale 1ns/100ps
`include "cfg_diag_consts.svh"
module pin_cell (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic soft_reset,
	input wire logic dir_wr,
	input wire logic dir_wdata,
	input wire logic data_wr,
	input wire logic data_wdata,
	input wire logic secondary_fn,
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe,
	output logic dir_bit,
	output logic read_bit
);
	logic dir_reg;
	logic dir_next;
	logic out_reg;
	logic out_next;

	always_comb begin
		dir_next = dir_reg;
		out_next = out_reg;
		if (soft_reset) begin
			dir_next = 1'b0;
			out_next = 1'b0;
		end else begin
			if (dir_wr) begin
				dir_next = dir_wdata;
			end
			if (data_wr && dir_reg && !secondary_fn) begin
				out_next = data_wdata;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			dir_reg <= 1'b0;
			out_reg <= 1'b0;
		end else begin
			dir_reg <= dir_next;
			out_reg <= out_next;
		end
	end

	assign pin_out = out_reg;
	assign pin_oe = dir_reg && !secondary_fn;
	assign dir_bit = dir_reg;
	assign read_bit = (dir_reg && !secondary_fn) ? out_reg : pin_in;
endmodule // pin_cell

/* File: cfg_diag_regs.sv */
// Pin data register and transaction-layer diagnostic register 0 behind configuration accesses.
//
// Functional notes
// - Input-mode pin data bits read pin level.
// - Output-mode write sets driven pin level.
// - Pin data bits 15:5 read zero.
// - Link, global, power-on resets restore defaults, except bit 18.
// - Bits 31:24 show captured bus number.
// - Bits 23:19 show captured device number.
// - Bit 18 selects alternate error reporting.
// - Read-only reserved diagnostic fields read zero.
// - Bit 2 enables config access memory registers.
// - Bit 0 holds clock request asserted.
// - Writes ignored for input or secondary pins.
// - Direction register, input default at reset.
`timescale 1ns/100ps
`include "cfg_diag_consts.svh"
module cfg_diag_regs
	import cfg_diag_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic link_reset,
	input wire logic global_reset_input,
	input wire logic power_on_reset,
	input wire cfg_req_s cfg_req,
	output logic [31:0] cfg_rdata,
	output logic cfg_ack,
	input wire captured_id_s captured_id,
	input wire logic [4:0] secondary_fn,
	input wire logic [4:0] pin_in,
	output logic [4:0] pin_out,
	output logic [4:0] pin_oe,
	input wire logic clock_request_internal,
	output logic clock_request_out,
	output logic alternate_error_method_select,
	output logic cfg_mem_access_enable
);
	logic soft_reset;
	logic any_req;
	logic pin_data_hit;
	logic pin_dir_hit;
	logic diag_hit;
	logic data_wr;
	logic dir_wr;
	logic diag_wr;
	logic [31:0] lane_merge;
	logic alt_err_reg;
	logic alt_err_next;
	logic cfg_mem_reg;
	logic cfg_mem_next;
	logic clkreq_reg;
	logic clkreq_next;
	logic [1:0] rsvd_hi_reg;
	logic [1:0] rsvd_hi_next;
	logic [4:0] rsvd_mid_reg;
	logic [4:0] rsvd_mid_next;
	logic rsvd_lo_reg;
	logic rsvd_lo_next;
	logic [31:0] diag_view;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic ack_reg;
	logic ack_next;
	logic [4:0] dir_bits;
	logic [4:0] read_bits;
	logic [15:0] pin_view;
	logic [15:0] dir_view;

	assign soft_reset = link_reset || global_reset_input || power_on_reset;
	assign any_req = cfg_req.rd || cfg_req.wr;

	// Offsets are decoded once so that the write strobes and the read mux agree.
	always_comb begin
		pin_data_hit = 1'b0;
		pin_dir_hit = 1'b0;
		diag_hit = 1'b0;
		if (cfg_req.addr == `PIN_DATA_OFFSET) begin
			pin_data_hit = 1'b1;
		end else if (cfg_req.addr == `PIN_DIR_OFFSET) begin
			pin_dir_hit = 1'b1;
		end else if (cfg_req.addr == `DIAG0_OFFSET) begin
			diag_hit = 1'b1;
		end
	end

	assign data_wr = cfg_req.wr && pin_data_hit && cfg_req.be[0];
	assign dir_wr = cfg_req.wr && pin_dir_hit && cfg_req.be[0];
	assign diag_wr = cfg_req.wr && diag_hit;

	// Each pin keeps its own direction bit and output latch.
	genvar i;
	generate
		for (i = 0; i < `PIN_COUNT; i = i + 1) begin : g_pin
			pin_cell u_pin (
				.mclk(mclk),
				.rst_b(rst_b),
				.soft_reset(soft_reset),
				.dir_wr(dir_wr),
				.dir_wdata(cfg_req.wdata[i]),
				.data_wr(data_wr),
				.data_wdata(cfg_req.wdata[i]),
				.secondary_fn(secondary_fn[i]),
				.pin_in(pin_in[i]),
				.pin_out(pin_out[i]),
				.pin_oe(pin_oe[i]),
				.dir_bit(dir_bits[i]),
				.read_bit(read_bits[i])
			);
		end
	endgenerate

	assign pin_view = {11'h000, read_bits} & `PIN_DATA_MASK;
	assign dir_view = {11'h000, dir_bits} & `PIN_DATA_MASK;

	// A diagnostic byte whose lane is not enabled keeps its current contents.
	genvar lane;
	generate
		for (lane = 0; lane < `DIAG0_LANES; lane = lane + 1) begin : g_lane
			assign lane_merge[lane*`LANE_BITS +: `LANE_BITS] = cfg_req.be[lane] ?
				cfg_req.wdata[lane*`LANE_BITS +: `LANE_BITS] : diag_view[lane*`LANE_BITS +: `LANE_BITS];
		end
	endgenerate

	// The view is rebuilt from the field registers and captured_id, so a read-only reserved bit can never hold a one.
	always_comb begin
		diag_view = `ZERO32;
		diag_view[`DIAG0_BUS_HI:`DIAG0_BUS_LO] = captured_id.bus_number;
		diag_view[`DIAG0_DEV_HI:`DIAG0_DEV_LO] = captured_id.device_number;
		diag_view[`DIAG0_ALT_ERR_BIT] = alt_err_reg;
		diag_view[`DIAG0_RSVD_HI_HI:`DIAG0_RSVD_HI_LO] = rsvd_hi_reg;
		diag_view[`DIAG0_RSVD_MID_HI:`DIAG0_RSVD_MID_LO] = rsvd_mid_reg;
		diag_view[`DIAG0_CFG_MEM_BIT] = cfg_mem_reg;
		diag_view[`DIAG0_RSVD_LO_BIT] = rsvd_lo_reg;
		diag_view[`DIAG0_CLKREQ_BIT] = clkreq_reg;
	end

	// Error method select.
	// This bit carries no reset mark, so only the pin reset clears it.
	// Writes that meet a soft reset are dropped like every other field.
	always_comb begin
		alt_err_next = alt_err_reg;
		if (diag_wr && !soft_reset) begin
			alt_err_next = lane_merge[`DIAG0_ALT_ERR_BIT];
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			alt_err_reg <= `ALT_ERR_RESET;
		end else begin
			alt_err_reg <= alt_err_next;
		end
	end

	always_comb begin
		cfg_mem_next = cfg_mem_reg;
		if (soft_reset) begin
			cfg_mem_next = `CFG_MEM_RESET;
		end else if (diag_wr) begin
			cfg_mem_next = lane_merge[`DIAG0_CFG_MEM_BIT];
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_mem_reg <= `CFG_MEM_RESET;
		end else begin
			cfg_mem_reg <= cfg_mem_next;
		end
	end

	// Clock request hold.
	// Resets to one so that the clock is requested from power-up on.
	always_comb begin
		clkreq_next = clkreq_reg;
		if (soft_reset) begin
			clkreq_next = `CLKREQ_RESET;
		end else if (diag_wr) begin
			clkreq_next = lane_merge[`DIAG0_CLKREQ_BIT];
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			clkreq_reg <= `CLKREQ_RESET;
		end else begin
			clkreq_reg <= clkreq_next;
		end
	end

	// The writable reserved fields store what is written; software must keep them zero.
	// No logic depends on them, so a stray one only shows up on read-back.
	always_comb begin
		rsvd_hi_next = rsvd_hi_reg;
		if (soft_reset) begin
			rsvd_hi_next = `RSVD_HI_RESET;
		end else if (diag_wr) begin
			rsvd_hi_next = lane_merge[`DIAG0_RSVD_HI_HI:`DIAG0_RSVD_HI_LO];
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rsvd_hi_reg <= `RSVD_HI_RESET;
		end else begin
			rsvd_hi_reg <= rsvd_hi_next;
		end
	end

	// The middle reserved field spans two byte lanes and merges per lane.
	always_comb begin
		rsvd_mid_next = rsvd_mid_reg;
		if (soft_reset) begin
			rsvd_mid_next = `RSVD_MID_RESET;
		end else if (diag_wr) begin
			rsvd_mid_next = lane_merge[`DIAG0_RSVD_MID_HI:`DIAG0_RSVD_MID_LO];
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rsvd_mid_reg <= `RSVD_MID_RESET;
		end else begin
			rsvd_mid_reg <= rsvd_mid_next;
		end
	end

	always_comb begin
		rsvd_lo_next = rsvd_lo_reg;
		if (soft_reset) begin
			rsvd_lo_next = `RSVD_LO_RESET;
		end else if (diag_wr) begin
			rsvd_lo_next = lane_merge[`DIAG0_RSVD_LO_BIT];
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rsvd_lo_reg <= `RSVD_LO_RESET;
		end else begin
			rsvd_lo_reg <= rsvd_lo_next;
		end
	end

	// Reads answer one cycle after the request; unmapped offsets read zero.
	// Output-mode pins read back their latch rather than the pad level.
	always_comb begin
		rdata_next = rdata_reg;
		if (cfg_req.rd) begin
			if (pin_data_hit) begin
				rdata_next = {`ZERO16, pin_view};
			end else if (pin_dir_hit) begin
				rdata_next = {`ZERO16, dir_view};
			end else if (diag_hit) begin
				rdata_next = diag_view;
			end else begin
				rdata_next = `ZERO32;
			end
		end
	end

	// The pin level seen by software is the one present at the request edge.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_reg <= `ZERO32;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// Every access is acknowledged, even one that a soft reset swallows.
	always_comb begin
		ack_next = any_req;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= ack_next;
		end
	end

	assign cfg_rdata = rdata_reg;
	assign cfg_ack = ack_reg;
	assign alternate_error_method_select = alt_err_reg;
	assign cfg_mem_access_enable = cfg_mem_reg;
	// Force clock request.
	// The internal request still works while the hold bit is clear.
	assign clock_request_out = clkreq_reg || clock_request_internal;
endmodule // cfg_diag_regs

/* File: cfg_diag_regs_chk.sv */
// Assertions on the ports of the pin data and diagnostic register block.
`timescale 1ns/100ps
module cfg_diag_regs_chk
	import cfg_diag_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic link_reset,
	input wire logic global_reset_input,
	input wire logic power_on_reset,
	input wire cfg_req_s cfg_req,
	input wire logic [31:0] cfg_rdata,
	input wire captured_id_s captured_id,
	input wire logic [4:0] pin_in,
	input wire logic [4:0] pin_out,
	input wire logic [4:0] pin_oe,
	input wire logic clock_request_internal,
	input wire logic clock_request_out,
	input wire logic alternate_error_method_select,
	input wire logic cfg_mem_access_enable
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	wire logic rp = cfg_req.rd && cfg_req.addr == 8'hB6;
	wire logic rg = cfg_req.rd && cfg_req.addr == 8'hC0;
	wire logic wr = cfg_req.wr && cfg_req.be[0] && !link_reset && !global_reset_input
		&& !power_on_reset;
	property p_rst; link_reset |=> clock_request_out && pin_oe == 5'h00; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_clk; clock_request_internal |-> clock_request_out; endproperty
	a_clk: assert property (p_clk) else $error("clkreq");
	property p_rsv; rp |=> cfg_rdata[15:5] == 11'h000; endproperty
	a_rsv: assert property (p_rsv) else $error("pin rsv");
	property p_ro; rg |=> (cfg_rdata & 32'h00033078) == 32'h00000000; endproperty
	a_ro: assert property (p_ro) else $error("diag rsv");
	property p_id; rg |=> cfg_rdata[31:19] == $past(captured_id); endproperty
	a_id: assert property (p_id) else $error("id");
	property p_in; rp && pin_oe == 5'h00 |=> cfg_rdata[4:0] == $past(pin_in); endproperty
	a_in: assert property (p_in) else $error("pin in");
	property p_out; wr && cfg_req.addr == 8'hB6 && &pin_oe |=>
		pin_out == $past(cfg_req.wdata[4:0]); endproperty
	a_out: assert property (p_out) else $error("pin out");
	property p_ctl; wr && cfg_req.addr == 8'hC0 && cfg_req.be[2] |=> cfg_mem_access_enable
		== $past(cfg_req.wdata[2]) && alternate_error_method_select == $past(cfg_req.wdata[18]); endproperty
	a_ctl: assert property (p_ctl) else $error("ctl");
endmodule // cfg_diag_regs_chk
bind cfg_diag_regs cfg_diag_regs_chk i_chk (.*);

/* File: pin_board.sv */
// Board model of the five pins.
`timescale 1ns/100ps
module pin_board (
	input wire logic [4:0] pin_out,
	input wire logic [4:0] pin_oe,
	input wire logic [4:0] ext_level,
	output logic [4:0] pin_in
);
	assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule // pin_board

/* File: tb_cfg_diag_regs.sv */
// Self-checking bench for the pin data and diagnostic registers.
`timescale 1ns/100ps
module tb_cfg_diag_regs;
	import cfg_diag_pkg::*;
	logic mclk = 0, rst_b = 0, clock_request_internal = 0, cfg_ack, clock_request_out;
	logic alternate_error_method_select, cfg_mem_access_enable;
	logic [2:0] sr = 0;
	logic [4:0] secondary_fn = 0, ext_level, pin_in, pin_out, pin_oe, p;
	cfg_req_s cfg_req = '0;
	captured_id_s captured_id;
	logic [31:0] cfg_rdata, d;
	logic [63:0] q[$];
	int bad_count = 0, num_checks = 0, cyc = 0;
	wire logic link_reset = sr[0], global_reset_input = sr[1], power_on_reset = sr[2];
	cfg_diag_regs i_cfg_diag_regs (.*);
	pin_board i_pin_board (.*);
	initial forever #4 mclk = ~mclk;
	task chk(string n, logic [31:0] s, logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s exp %h seen %h", n, e, s);
		end
	endtask
	task summarize;
		if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task acc(logic r, logic [7:0] a, logic [31:0] w, logic [31:0] m, logic [31:0] e);
		@(posedge mclk);
		#1 cfg_req = '{r, !r, a, w, 4'hF};
		q.push_back({m, e});
		@(posedge mclk);
		#1 cfg_req = '0;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 600) begin
			bad_count++;
			summarize;
		end
		if (cfg_ack === 1'h1 && q.size() > 0) begin
			chk("rdata", cfg_rdata & q[0][63:32], q[0][31:0]);
			void'(q.pop_front());
		end
	end
	initial begin
		void'($urandom(32'hB867));
		ext_level = $urandom;
		captured_id = $urandom;
		repeat (6) @(posedge mclk);
		#1 rst_b = 1;
		acc(1'h1, 8'hC0, 0, '1, {captured_id, 19'h00001});
		acc(1'h1, 8'hB6, 0, '1, ext_level);
		for (int i = 0; i < 3; i++) begin
			acc(1'h0, 8'hC0, 32'hFFFF307D, 0, 0);
			acc(1'h1, 8'hC0, 0, '1, {captured_id, 19'h40005});
			chk("ctl", {alternate_error_method_select, cfg_mem_access_enable}, 2'h3);
			@(posedge mclk);
			#1 sr = 3'h1 << i;
			@(posedge mclk);
			#1 sr = 0;
			acc(1'h1, 8'hC0, 0, '1, {captured_id, 19'h40001});
		end
		clock_request_internal = $urandom;
		acc(1'h0, 8'hC0, 0, 0, 0);
		chk("clkreq", clock_request_out, clock_request_internal);
		acc(1'h0, 8'hB4, 32'h1F, 0, 0);
		d = $urandom;
		acc(1'h0, 8'hB6, d, 0, 0);
		chk("out", pin_out, d[4:0]);
		acc(1'h1, 8'hB6, 0, '1, d[4:0]);
		secondary_fn = $urandom;
		p = (~d[4:0] & ~secondary_fn) | (d[4:0] & secondary_fn);
		acc(1'h0, 8'hB6, ~d, 0, 0);
		chk("sec", pin_out, p);
		secondary_fn = 0;
		acc(1'h0, 8'hB4, 0, 0, 0);
		acc(1'h0, 8'hB6, d, 0, 0);
		chk("inmode", pin_out, p);
		acc(1'h1, 8'hB6, 0, '1, ext_level);
		acc(1'h0, 8'hC0, 32'h1, 0, 0);
		acc(1'h1, 8'hC0, 0, '1, {captured_id, 19'h00001});
		repeat (3) @(posedge mclk);
		summarize;
	end
endmodule // tb_cfg_diag_regs
